// *** common/addr_match_pkg.sv ***
package addr_match_pkg;
   // ==========================================
   // address format
   // ==========================================
   localparam int ADDR_BITS = 10;
   localparam int NUM_OWN = 4;
   localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
   localparam int PREFIX_POS = 3;
   localparam int UPPER_POS = 1;
   localparam int DIR_POS = 0;
   localparam int BIT_COUNT_RESET = 0;
   localparam int BYTE_BITS = 8;

   typedef enum logic [2:0] {
      IDLE,
      FIRST_BYTE,
      FIRST_ACK,
      SECOND_BYTE,
      SECOND_ACK,
      DATA_PHASE,
      IGNORE
   } match_state_t;
endpackage

// *** common/own_addr_if.sv ***
`timescale 1ns/100ps
// own address table, shared between matcher and comparator
interface own_addr_if #(parameter int NUM = 4, parameter int AW = 10);
   logic [AW-1:0] ownAddr [NUM];
   logic [NUM-1:0] ownValid;
   logic [1:0] rxUpper;
   logic [7:0] rxLower;
   logic upperHit;
   logic fullHit;
   modport matcher (output ownAddr, output ownValid, output rxUpper,
      output rxLower, input upperHit, input fullHit);
   modport compare (input ownAddr, input ownValid, input rxUpper,
      input rxLower, output upperHit, output fullHit);
endinterface

// *** hdl/own_addr_compare.sv ***
`timescale 1ns/100ps
// combinational comparison of received address against own table
module own_addr_compare #(parameter int NUM = 4) (
   own_addr_if.compare tbl
);
   logic [NUM-1:0] upperVec;
   logic [NUM-1:0] fullVec;

   // ==========================================
   // per-entry comparators
   // ==========================================
   genvar i;
   generate
      for (i = 0; i < NUM; i++) begin : g_cmp
         assign upperVec[i] = tbl.ownValid[i] &&
            (tbl.ownAddr[i][addr_match_pkg::ADDR_BITS-1 -: 2] ==
             tbl.rxUpper);
         // both halves from the same entry, never mixed
         assign fullVec[i] = tbl.ownValid[i] &&
            (tbl.ownAddr[i] == {tbl.rxUpper, tbl.rxLower});
      end
   endgenerate

   assign tbl.upperHit = |upperVec;
   assign tbl.fullHit = |fullVec;
endmodule

// *** hdl/i2c_multi_address_10bit_match.sv ***
`timescale 1ns/100ps
// Operation
// - up to four independent 10-bit own addresses, all compared
// - first byte is 11110, two address msbs, then direction bit
// - second byte carries the eight low address bits
// - ack first byte when its msbs equal the msbs of any enabled own address
// - ack second byte only when one own address matches all ten
module i2c_multi_address_10bit_match #(
   parameter int NUM_OWN = addr_match_pkg::NUM_OWN
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // own address configuration
   input wire logic [9:0] ownAddr0,
   input wire logic [9:0] ownAddr1,
   input wire logic [9:0] ownAddr2,
   input wire logic [9:0] ownAddr3,
   input wire logic [3:0] ownEnable,
   // bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe_n,
   // status
   output logic addressed,
   output logic readDir,
   output logic [1:0] matchIndexValid
);
   // ==========================================
   // module state
   // ==========================================
   // everything registered lives here, outputs included, so the single
   // clocked process below is the only place that holds state
   typedef struct packed {
      // pin synchronisers and previous synchronised levels
      logic [1:0] sclSync;
      logic [1:0] sdaSync;
      logic sclPrev;
      logic sdaPrev;
      // address phase sequencing and captured halves
      addr_match_pkg::match_state_t state;
      logic [3:0] bitCnt;
      logic [7:0] shifter;
      logic [1:0] upper;
      logic [7:0] lower;
      logic dir;
      // acknowledge and status
      logic ackDrive;
      logic addressed;
      logic readDir;
      logic [1:0] seen;
      // registered pin outputs and ignore flag
      logic sdaLevel;
      logic sdaOe_n;
      logic ignoring;
   } state_t;

   // current state and the copy that the next clock edge loads
   state_t cur;
   state_t next_cur;

   own_addr_if #(.NUM(NUM_OWN), .AW(addr_match_pkg::ADDR_BITS)) tbl ();

   // ==========================================
   // own address table
   // ==========================================
   // entries are plain inputs held steady by the surrounding logic; they
   // are compared every cycle, so a change in mid address phase takes
   // effect at whichever ack decision comes next
   assign tbl.ownAddr[0] = ownAddr0;
   assign tbl.ownAddr[1] = ownAddr1;
   assign tbl.ownAddr[2] = ownAddr2;
   assign tbl.ownAddr[3] = ownAddr3;
   assign tbl.ownValid = ownEnable;
   assign tbl.rxUpper = cur.upper;
   assign tbl.rxLower = cur.lower;

   // ==========================================
   // comparator
   // ==========================================
   // one comparator per entry; both hit flags settle within the cycle
   own_addr_compare #(.NUM(NUM_OWN)) u_cmp (
      .tbl(tbl.compare)
   );

   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;

   // ==========================================
   // bus events
   // ==========================================
   // edges seen on synchronised copies only; the prev bits are preset high
   // in reset, the idle level of both lines, so no false start follows
   // reset. the cost is about three clocks of latency on every event.
   assign sclRise = cur.sclSync[1] && !cur.sclPrev;
   assign sclFall = !cur.sclSync[1] && cur.sclPrev;
   assign startCond = cur.sclSync[1] && cur.sclPrev &&
      !cur.sdaSync[1] && cur.sdaPrev;
   assign stopCond = cur.sclSync[1] && cur.sclPrev &&
      cur.sdaSync[1] && !cur.sdaPrev;

   // ==========================================
   // next state
   // ==========================================
   // a byte ends at the synchronised scl fall after its eighth rise. the
   // ack decision is taken in the first cycle of the ack state and the
   // pin is pulled one clock later, so the controller must keep scl low
   // for more than about four clocks or the ack misses the rising edge.
   // the pull is dropped at the fall that ends the ack clock, again one
   // synchronised edge late, which still lies inside the low phase.
   // a refused byte leaves the line alone and parks in the ignore state;
   // only a start condition brings the matcher back, a stop only idles.
   // stop and start are checked ahead of the state machine so that a
   // repeated start in the middle of any phase restarts the address.
   always_comb begin
      next_cur = cur;
      next_cur.sclSync = {cur.sclSync[0], sclIn};
      next_cur.sdaSync = {cur.sdaSync[0], sdaIn};
      next_cur.sclPrev = cur.sclSync[1];
      next_cur.sdaPrev = cur.sdaSync[1];
      if (startCond) begin
         // repeated start also leaves ignore state
         next_cur.state = addr_match_pkg::FIRST_BYTE;
         next_cur.bitCnt = 4'(addr_match_pkg::BIT_COUNT_RESET);
         next_cur.ackDrive = 1'b0;
         next_cur.addressed = 1'b0;
         next_cur.seen = 2'h0;
      end else if (stopCond) begin
         next_cur.state = addr_match_pkg::IDLE;
         next_cur.ackDrive = 1'b0;
         next_cur.addressed = 1'b0;
      end else begin
         case (cur.state)
            addr_match_pkg::FIRST_BYTE,
            addr_match_pkg::SECOND_BYTE: begin
               if (sclRise) begin
                  next_cur.shifter = {cur.shifter[6:0], cur.sdaSync[1]};
                  next_cur.bitCnt = cur.bitCnt + 4'h1;
               end else if (sclFall &&
                            cur.bitCnt == 4'(addr_match_pkg::BYTE_BITS)) begin
                  next_cur.bitCnt = 4'h0;
                  if (cur.state == addr_match_pkg::FIRST_BYTE) begin
                     next_cur.upper =
                        cur.shifter[addr_match_pkg::UPPER_POS +: 2];
                     next_cur.dir = cur.shifter[addr_match_pkg::DIR_POS];
                     next_cur.state = addr_match_pkg::FIRST_ACK;
                  end else begin
                     next_cur.lower = cur.shifter;
                     next_cur.state = addr_match_pkg::SECOND_ACK;
                  end
               end
            end
            addr_match_pkg::FIRST_ACK: begin
               // decide once upper bits are latched, before ack clock
               if (cur.seen == 2'h0) begin
                  next_cur.seen = 2'h1;
                  if (cur.shifter[addr_match_pkg::PREFIX_POS +: 5] ==
                      addr_match_pkg::TEN_BIT_PREFIX &&
                      tbl.upperHit) begin
                     next_cur.ackDrive = 1'b1;
                  end else begin
                     next_cur.state = addr_match_pkg::IGNORE;
                  end
               end else if (sclFall) begin
                  next_cur.ackDrive = 1'b0;
                  next_cur.seen = 2'h0;
                  next_cur.state = addr_match_pkg::SECOND_BYTE;
               end
            end
            addr_match_pkg::SECOND_ACK: begin
               if (cur.seen == 2'h0) begin
                  next_cur.seen = 2'h1;
                  // both halves must come from one entry, never two
                  if (tbl.fullHit) begin
                     next_cur.ackDrive = 1'b1;
                  end else begin
                     next_cur.state = addr_match_pkg::IGNORE;
                  end
               end else if (sclFall) begin
                  next_cur.ackDrive = 1'b0;
                  next_cur.addressed = 1'b1;
                  next_cur.readDir = cur.dir;
                  next_cur.state = addr_match_pkg::DATA_PHASE;
               end
            end
            default: begin
               // idle, data and ignore wait for start or stop
               next_cur.ackDrive = 1'b0;
            end
         endcase
      end
      // output copies follow the decisions made above in the same cycle
      next_cur.sdaLevel = 1'b0; // open drain: only ever pulls low
      next_cur.sdaOe_n = !next_cur.ackDrive;
      next_cur.ignoring = next_cur.state == addr_match_pkg::IGNORE;
   end

   // ==========================================
   // registers
   // ==========================================
   // synchronous reset only; the pin copies are preset to the idle level
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cur <= '{sclSync: 2'h3, sdaSync: 2'h3, sclPrev: 1'b1,
                  sdaPrev: 1'b1, state: addr_match_pkg::IDLE,
                  sdaOe_n: 1'b1, default: '0};
      end else begin
         cur <= next_cur;
      end
   end

   // ==========================================
   // outputs
   // ==========================================
   // every output is a field of the state register, no gate after it
   assign sdaOut = cur.sdaLevel;
   assign sdaOe_n = cur.sdaOe_n; // released unless acknowledging
   assign addressed = cur.addressed;
   assign readDir = cur.readDir;
   assign matchIndexValid = {cur.addressed, cur.ignoring};
endmodule

// *** bench/i2c_ctrl_model.sv ***
`timescale 1ns/100ps
// =========
// bus controller; a released sda reads high through the pull-up
module i2c_ctrl_model (
   // clock and bus
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic pullLow
);
   initial begin
      scl = 1'b1;
      pullLow = 1'b0;
   end
   // quarter bit; scl low lasts 8 clocks so the ack is set in time
   task automatic q();
      repeat (4) @(negedge clk);
   endtask
   // start, also used as a repeated start
   task automatic start();
      pullLow = 1'b0;
      q();
      scl = 1'b1;
      q();
      pullLow = 1'b1;
      q();
      scl = 1'b0;
   endtask
   task automatic stop();
      pullLow = 1'b1;
      q();
      scl = 1'b1;
      q();
      pullLow = 1'b0;
      q();
   endtask
   // one bit: drive while scl low, sample mid high
   task automatic bitx(input logic b, output logic s);
      q();
      pullLow = !b;
      q();
      scl = 1'b1;
      q();
      s = sda;
      q();
      scl = 1'b0;
   endtask
   // byte msb first, then ack slot released; ack low means taken
   task automatic send(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(v[i], s);
      bitx(1'b1, ack);
   endtask
endmodule

// *** bench/i2c_match_props.sv ***
`timescale 1ns/100ps
// =========
// port checks of the address matcher
module i2c_match_props (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // watched ports
   input wire logic [3:0] ownEnable,
   input wire logic sdaOut,
   input wire logic sdaOe_n,
   input wire logic addressed,
   input wire logic [1:0] matchIndexValid
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   ignore_no_ack_a: assert property (matchIndexValid[0] |->
      sdaOe_n && !addressed)
      else $error("ack while ignoring");
   addr_copy_a: assert property (matchIndexValid[1] == addressed)
      else $error("status copy differs");
   addr_after_ack_a: assert property ($rose(addressed) |->
      !$past(sdaOe_n) || !$past(sdaOe_n, 2))
      else $error("addressed without ack");
   ack_low_a: assert property (!sdaOe_n |-> !sdaOut)
      else $error("ack not low");
   ack_one_bit_a: assert property ($fell(sdaOe_n) |->
      !sdaOe_n[*8] ##[1:30] sdaOe_n)
      else $error("ack length");
   addr_enabled_a: assert property (addressed |->
      ownEnable != 4'h0)
      else $error("match on no entry");
endmodule
bind i2c_multi_address_10bit_match i2c_match_props i_i2c_match_props (
   .sys_clk(sys_clk), .srst(srst), .ownEnable(ownEnable),
   .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addressed(addressed),
   .matchIndexValid(matchIndexValid));

// *** bench/test_i2c_multi_address_10bit_match.sv ***
`timescale 1ns/100ps
// =========
// bench: four entries, entry two starts disabled
module test_i2c_multi_address_10bit_match;
   logic sys_clk;
   logic srst;
   logic [3:0] ownEnable;
   logic scl, pullLow, sdaOut, sdaOe_n, addressed, readDir;
   logic [1:0] matchIndexValid;
   wire logic sda;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;
   // wired-and with pull-up
   assign sda = !(pullLow || (!sdaOe_n && !sdaOut));
   i2c_multi_address_10bit_match i_i2c_multi_address_10bit_match (
      .sys_clk(sys_clk), .srst(srst),
      .ownAddr0(10'h155), .ownAddr1(10'h2aa),
      .ownAddr2(10'h0f0), .ownAddr3(10'h3c3),
      .ownEnable(ownEnable), .sclIn(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addressed(addressed),
      .readDir(readDir), .matchIndexValid(matchIndexValid));
   i2c_ctrl_model i_i2c_ctrl_model (
      .clk(sys_clk), .sda(sda), .scl(scl), .pullLow(pullLow));
   task automatic end_of_test();
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: bit mismatch", $time);
      end
   endtask
   // both address bytes, then let the status settle past the sync delay
   task automatic xfer(input logic [9:0] a, input logic rd,
      output logic k1, output logic k2);
      i_i2c_ctrl_model.start();
      i_i2c_ctrl_model.send({5'h1e, a[9:8], rd}, k1);
      i_i2c_ctrl_model.send(a[7:0], k2);
      repeat (8) @(negedge sys_clk);
   endtask
   task automatic full_match();
      logic k1, k2;
      xfer(10'h155, 1'b0, k1, k2);
      chk(k1, 1'b0);
      chk(k2, 1'b0);
      chk(addressed, 1'b1);
      chk(matchIndexValid[1], 1'b1);
      chk(matchIndexValid[0], 1'b0);
      i_i2c_ctrl_model.stop();
   endtask
   // upper bits of entry zero, lower bits of entry one
   task automatic mixed_halves();
      logic k1, k2, k3;
      xfer(10'h1aa, 1'b0, k1, k2);
      chk(k1, 1'b0);
      chk(k2, 1'b1);
      chk(addressed, 1'b0);
      chk(matchIndexValid[0], 1'b1);
      i_i2c_ctrl_model.send(8'h55, k3);
      chk(k3, 1'b1);
      i_i2c_ctrl_model.stop();
   endtask
   // disabled entry is refused, then answers once enabled
   task automatic entry_enable();
      logic k1, k2;
      xfer(10'h0f0, 1'b0, k1, k2);
      chk(k1, 1'b1);
      chk(k2, 1'b1);
      i_i2c_ctrl_model.stop();
      ownEnable = 4'hf;
      xfer(10'h0f0, 1'b0, k1, k2);
      chk(k1, 1'b0);
      chk(k2, 1'b0);
      i_i2c_ctrl_model.stop();
   endtask
   task automatic last_read();
      logic k1, k2;
      xfer(10'h3c3, 1'b1, k1, k2);
      chk(k1, 1'b0);
      chk(k2, 1'b0);
      chk(readDir, 1'b1);
      i_i2c_ctrl_model.stop();
   endtask
   task automatic bad_prefix();
      logic k;
      i_i2c_ctrl_model.start();
      i_i2c_ctrl_model.send(8'he6, k);
      chk(k, 1'b1);
      chk(matchIndexValid[0], 1'b1);
      i_i2c_ctrl_model.stop();
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // hang guard, runs far beyond the roughly two thousand cycles needed
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      srst = 1'b1;
      ownEnable = 4'hb;
      repeat (20) @(negedge sys_clk);
      srst = 1'b0;
      full_match();
      mixed_halves();
      entry_enable();
      last_read();
      bad_prefix();
      end_of_test();
   end
endmodule
